//--- logic/usr_top.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module usr_top #(
    parameter int RX_DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input usr_pkg::usr_bus_t bus,
    output logic [7:0] rdata,
    input wire logic core_sleep,
    output logic wake_request,
    output logic irq_request,
    input usr_pkg::usr_pin_in_t pin_in,
    output usr_pkg::usr_pin_out_t pin_out
);
    import usr_pkg::*;

    // The FIFO pointer logic is one bit wide, so only two entries are served
    if (RX_DEPTH != 2)
    begin : g_depth_check
        $error("usr_top: RX_DEPTH must be 2");
    end

    usr_st_t st_reg;
    usr_st_t st_next;

    function automatic logic [3:0] nbits(input logic nine);
        return nine ? USR_BITS_9 : USR_BITS_8;
    endfunction : nbits

    logic sync_on;
    logic master;
    logic continuous_receive_enable;
    logic single_word_receive_enable;
    logic rx_on;
    logic tx_on;
    logic tx_run;
    logic brg_en;
    logic run;
    logic tick;
    logic rise;
    logic fall;
    logic rx_last;
    logic full;
    logic push;
    logic pop;
    logic receive_complete_flag;
    logic transmit_buffer_empty_flag;
    logic pend;
    logic [8:0] rx_word;
    logic [8:0] head;
    logic tail;

    assign sync_on = st_reg.rxsc[USR_B_SERIAL_PORT_ENABLE] & st_reg.txsc[USR_B_SYNC]; // [R26]
    assign master = st_reg.txsc[USR_B_CLOCK_SOURCE_MASTER_BIT];
    assign continuous_receive_enable = st_reg.rxsc[USR_B_CONTINUOUS_RECEIVE_ENABLE];
    assign single_word_receive_enable = st_reg.rxsc[USR_B_SINGLE_WORD_RECEIVE_ENABLE];
    // Single-word enable means nothing to a slave
    assign rx_on = sync_on & (continuous_receive_enable | (master & single_word_receive_enable)); // [R1] [R5] [R16]
    assign tx_on = sync_on & st_reg.txsc[USR_B_TRANSMIT_ENABLE_BIT];
    assign tx_run = tx_on & ~rx_on; // [R28]
    assign brg_en = st_reg.txsc[USR_B_TRANSMIT_ENABLE_BIT] | continuous_receive_enable | single_word_receive_enable; // [R24]
    assign run = sync_on & master & (rx_on | (tx_run & ~st_reg.trmt)); // [R27]
    assign tick = run & brg_en & (st_reg.brg_cnt == USR_RST_ZERO);
    // Slave edges come from comparing the second and third synchroniser stages
    assign rise = master ? (tick & ~st_reg.sck) : (st_reg.ck_s2 & ~st_reg.ck_s3); // [R16]
    assign fall = master ? (tick & st_reg.sck) : (~st_reg.ck_s2 & st_reg.ck_s3);
    assign rx_last = rx_on & fall
        & (st_reg.rx_cnt == nbits(st_reg.rxsc[USR_B_RX9]) - 4'h1);
    assign full = (st_reg.fcnt == USR_FIFO_FULL);
    assign push = rx_last & ~st_reg.overrun_error_bit & ~full; // [R6] [R12]
    assign pop = bus.re & (bus.addr == USR_OFS_RXHEAD) & (st_reg.fcnt != 2'h0);
    assign receive_complete_flag = (st_reg.fcnt != 2'h0); // [R8]
    assign transmit_buffer_empty_flag = ~st_reg.txbuf_full;
    assign head = st_reg.fifo[st_reg.rd_ptr];
    assign tail = st_reg.rd_ptr ^ st_reg.fcnt[0];
    assign pend = (receive_complete_flag & st_reg.enab[USR_B_RECEIVE_COMPLETE_FLAG]) | (transmit_buffer_empty_flag & st_reg.enab[USR_B_TRANSMIT_BUFFER_EMPTY_FLAG]); // [R7]

    always_comb
    begin
        rx_word = st_reg.receive_shift_register;
        rx_word[st_reg.rx_cnt] = st_reg.dt_s2; // [R2]
        if (!st_reg.rxsc[USR_B_RX9])
        begin
            rx_word[8] = 1'b0;
        end
    end

    always_comb
    begin
        st_next = st_reg;
        st_next.rdata = USR_RST_ZERO;
        st_next.ck_s1 = pin_in.ck;
        st_next.ck_s2 = st_reg.ck_s1;
        st_next.ck_s3 = st_reg.ck_s2;
        st_next.dt_s1 = pin_in.dt;
        st_next.dt_s2 = st_reg.dt_s1;

        if (bus.we)
        begin
            unique case (bus.addr)
                USR_OFS_INTCTL: st_next.intctl = bus.wdata;
                USR_OFS_FLAGS: st_next.flags_oth = bus.wdata & USR_WM_FLAGS;
                USR_OFS_RXSC:
                begin
                    st_next.rxsc = bus.wdata & USR_WM_RXSC;
                    if (!bus.wdata[USR_B_CONTINUOUS_RECEIVE_ENABLE])
                    begin
                        st_next.overrun_error_bit = 1'b0; // [R11]
                    end
                end
                USR_OFS_ENAB: st_next.enab = bus.wdata & USR_WM_ENAB;
                USR_OFS_TXSC: st_next.txsc = bus.wdata & USR_WM_TXSC;
                USR_OFS_BAUD: st_next.baud = bus.wdata;
                default: ;
            endcase
        end

        if (bus.re)
        begin
            unique case (bus.addr)
                USR_OFS_INTCTL: st_next.rdata = st_reg.intctl;
                USR_OFS_FLAGS:
                begin
                    st_next.rdata = st_reg.flags_oth;
                    st_next.rdata[USR_B_RECEIVE_COMPLETE_FLAG] = receive_complete_flag;
                    st_next.rdata[USR_B_TRANSMIT_BUFFER_EMPTY_FLAG] = transmit_buffer_empty_flag;
                end
                USR_OFS_RXSC:
                begin
                    // Ninth bit of the head entry, so read this before the data
                    st_next.rdata = st_reg.rxsc;
                    st_next.rdata[1] = st_reg.overrun_error_bit;
                    st_next.rdata[0] = receive_complete_flag & head[8]; // [R13] [R14]
                end
                USR_OFS_TXBUF: st_next.rdata = st_reg.txbuf;
                USR_OFS_RXHEAD: st_next.rdata = receive_complete_flag ? head[7:0] : USR_RST_ZERO; // [R9]
                USR_OFS_ENAB: st_next.rdata = st_reg.enab;
                USR_OFS_TXSC:
                begin
                    st_next.rdata = st_reg.txsc;
                    st_next.rdata[USR_B_TRMT] = st_reg.trmt;
                end
                USR_OFS_BAUD: st_next.rdata = st_reg.baud;
                default: st_next.rdata = USR_RST_ZERO;
            endcase
        end

        if (!brg_en || !run)
        begin
            st_next.brg_cnt = st_reg.baud; // [R24]
            st_next.sck = 1'b0;
        end
        else if (tick)
        begin
            st_next.brg_cnt = st_reg.baud;
            st_next.sck = ~st_reg.sck; // [R22]
        end
        else
        begin
            st_next.brg_cnt = st_reg.brg_cnt - 8'h01;
        end

        // Runs on any clock edge source, so it keeps going while the core sleeps
        if (!rx_on)
        begin
            st_next.rx_cnt = 4'h0;
        end
        else if (fall)
        begin
            st_next.receive_shift_register = rx_word; // [R17]
            st_next.rx_cnt = rx_last ? 4'h0 : st_reg.rx_cnt + 4'h1; // [R4]
        end
        // Set wins over a clearing write in the same cycle
        if (rx_last && full)
        begin
            st_next.overrun_error_bit = 1'b1; // [R10]
        end
        if (rx_last && master && !continuous_receive_enable)
        begin
            st_next.rxsc[USR_B_SINGLE_WORD_RECEIVE_ENABLE] = 1'b0; // [R3] [R25]
        end

        if (push)
        begin
            // Tail slot, whether or not the head is popped in the same cycle
            st_next.fifo[tail] = rx_word; // [R6]
        end
        if (pop)
        begin
            st_next.rd_ptr = ~st_reg.rd_ptr; // [R13]
        end
        if (push && !pop)
        begin
            st_next.fcnt = st_reg.fcnt + 2'h1;
        end
        else if (pop && !push)
        begin
            st_next.fcnt = st_reg.fcnt - 2'h1;
        end

        // Clearing the transmit enable resets the transmitter; a receive only parks it
        if (!tx_on)
        begin
            st_next.trmt = 1'b1;
            st_next.tx_cnt = 4'h0;
        end
        else if (st_reg.trmt && st_reg.txbuf_full)
        begin
            st_next.transmit_shift_register = {st_reg.txsc[USR_B_TRANSMIT_NINTH_BIT], st_reg.txbuf}; // [R18] [R19]
            st_next.trmt = 1'b0;
            st_next.txbuf_full = 1'b0; // [R19]
            st_next.tx_cnt = 4'h0;
        end
        else if (!st_reg.trmt && tx_run)
        begin
            if (rise && st_reg.tx_cnt != nbits(st_reg.txsc[USR_B_TX9]))
            begin
                st_next.dout = st_reg.transmit_shift_register[st_reg.tx_cnt]; // [R17]
                st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
            end
            else if (fall && st_reg.tx_cnt == nbits(st_reg.txsc[USR_B_TX9]))
            begin
                st_next.trmt = 1'b1;
            end
        end
        // Written after the load so a same-cycle write is never lost
        if (bus.we && bus.addr == USR_OFS_TXBUF)
        begin
            st_next.txbuf = bus.wdata;
            st_next.txbuf_full = 1'b1; // [R18]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg <= '0;
            st_reg.txsc <= USR_RST_TXSC;
            st_reg.trmt <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rdata;
    assign pin_out.ck_o = st_reg.sck;
    assign pin_out.ck_oe = sync_on & master; // [R23]
    assign pin_out.dt_o = st_reg.dout;
    assign pin_out.dt_oe = tx_run; // [R28] [R27]
    assign wake_request = core_sleep & pend; // [R20]
    assign irq_request = st_reg.intctl[USR_B_GIE] & st_reg.intctl[USR_B_PERIPHERAL_INTERRUPT_ENABLE] & pend; // [R20]

    a_fifo_bound: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
        st_reg.fcnt <= USR_FIFO_FULL)
        else $error("receive FIFO count above two");

    a_overrun_error_bit_blocks_fill: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
        st_reg.overrun_error_bit |=> st_reg.fcnt <= $past(st_reg.fcnt))
        else $error("FIFO filled while overrun set");

    // A read in the overrun cycle still takes its entry out
    a_overrun_set: assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
        (rx_last && full) |=> st_reg.overrun_error_bit
        && st_reg.fcnt == USR_FIFO_FULL - {1'b0, $past(pop)})
        else $error("overrun not flagged on full FIFO");

    a_push_sets_flag: assert property (@(posedge clk_sys) disable iff (!resetn) // [R6]
        push |=> receive_complete_flag ##0 st_reg.fcnt >= 2'h1)
        else $error("receive-complete not set after transfer");

    a_flag_falls_read: assert property (@(posedge clk_sys) disable iff (!resetn) // [R8]
        $fell(receive_complete_flag) |-> $past(pop))
        else $error("receive-complete cleared without a read");

    a_read_head: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
        pop |=> rdata == $past(head[7:0]))
        else $error("FIFO read returned wrong entry");

    a_single_stops: assert property (@(posedge clk_sys) disable iff (!resetn) // [R25]
        (rx_last && master && !continuous_receive_enable) |=> !single_word_receive_enable ##1 !st_reg.sck)
        else $error("single-word enable not cleared");

    a_continuous_receive_enable_clears_overrun_error_bit: assert property (@(posedge clk_sys) disable iff (!resetn) // [R11]
        (bus.we && bus.addr == USR_OFS_RXSC && !bus.wdata[USR_B_CONTINUOUS_RECEIVE_ENABLE] && !rx_last)
        |=> !st_reg.overrun_error_bit)
        else $error("overrun survived clearing continuous enable");

    a_half_duplex: assert property (@(posedge clk_sys) disable iff (!resetn) // [R28]
        rx_on |-> !pin_out.dt_oe)
        else $error("data pin driven during reception");

    a_tx_reset: assert property (@(posedge clk_sys) disable iff (!resetn) // [R24]
        !tx_on |=> st_reg.trmt && st_reg.tx_cnt == 4'h0)
        else $error("transmitter not reset when disabled");

    a_second_loads: assert property (@(posedge clk_sys) disable iff (!resetn) // [R19]
        (tx_on && st_reg.trmt && st_reg.txbuf_full && !bus.we)
        |=> !st_reg.trmt && transmit_buffer_empty_flag)
        else $error("buffered word did not move to shift register");

    a_brg_held: assert property (@(posedge clk_sys) disable iff (!resetn) // [R24]
        !brg_en |=> !st_reg.sck && st_reg.brg_cnt == $past(st_reg.baud))
        else $error("baud generator ran with all enables clear");

    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
        !bus.re |=> rdata == USR_RST_ZERO)
        else $error("read data stood beyond its cycle");

    a_slave_no_clock: assert property (@(posedge clk_sys) disable iff (!resetn) // [R16]
        !master |-> !pin_out.ck_oe)
        else $error("clock pin driven in slave mode");

    a_sck_idle: assert property (@(posedge clk_sys) disable iff (!resetn) // [R27]
        !run |=> !st_reg.sck)
        else $error("shift clock left high while stopped");

    a_txbuf_waits: assert property (@(posedge clk_sys) disable iff (!resetn) // [R18]
        (st_reg.txbuf_full && !st_reg.trmt) |=> st_reg.txbuf_full)
        else $error("buffered word left while shifter busy");

    a_continuous_keeps: assert property (@(posedge clk_sys) disable iff (!resetn) // [R4]
        (rx_last && continuous_receive_enable && !bus.we) |=> rx_on)
        else $error("continuous reception stopped after a word");

    a_push_in_order: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
        push |=> st_reg.fifo[$past(tail)] == $past(rx_word))
        else $error("received word not stored at FIFO tail");

    a_ninth_zero: assert property (@(posedge clk_sys) disable iff (!resetn) // [R14]
        (push && !st_reg.rxsc[USR_B_RX9]) |-> !rx_word[8])
        else $error("ninth bit stored with nine-bit option off");

    a_overrun_error_bit_sticky: assert property (@(posedge clk_sys) disable iff (!resetn) // [R11]
        (st_reg.overrun_error_bit && !(bus.we && bus.addr == USR_OFS_RXSC && !bus.wdata[USR_B_CONTINUOUS_RECEIVE_ENABLE]))
        |=> st_reg.overrun_error_bit)
        else $error("overrun cleared without clearing continuous enable");

    a_flag_write_ignored: assert property (@(posedge clk_sys) disable iff (!resetn) // [R8]
        (bus.we && bus.addr == USR_OFS_FLAGS && !push && !pop) |=> receive_complete_flag == $past(receive_complete_flag))
        else $error("receive-complete changed by a write");

    a_rx_count_idle: assert property (@(posedge clk_sys) disable iff (!resetn) // [R1]
        !rx_on |=> st_reg.rx_cnt == 4'h0)
        else $error("receive bit count moved while disabled");
endmodule : usr_top

//--- logic/usr_pkg.sv
// Function
// [R1] Synchronous reception starts when single-word or continuous receive enable is set
// [R2] Received data is sampled on the falling shift clock edge
// [R3] Single-word enable receives exactly one word then stops
// [R4] Continuous enable receives back to back until cleared
// [R5] With both enables set, continuous reception wins
// [R6] Finished word moves into the FIFO if room, then receive-complete sets
// [R7] Receive request needs its enable; the flag sets regardless
// [R8] Receive-complete is read-only and clears when the FIFO reads empty
// [R9] Receive data is a two-entry FIFO read out in order
// [R10] Word finishing while FIFO is full sets overrun and is lost
// [R11] Overrun clears only when continuous receive enable is cleared
// [R12] While overrun is set no word enters the FIFO
// [R13] Each FIFO read updates the ninth-bit status to the next entry
// [R14] Nine-bit option captures a ninth bit shown in the status field
// [R15] Software sets up divisor and mode bits with both enables clear
// [R16] Slave mode takes the shift clock from the pin
// [R17] Shifting continues in sleep since the clock is external
// [R18] Two words written: first shifts out, second stays, empty flag clear
// [R19] After the first word, the second loads and the empty flag sets
// [R20] Empty flag with its enable wakes the core and may vector
// [R21] Software sets up slave transmit then enables, loads ninth bit, writes data
// [R22] Software selects master with mode bits; the baud generator drives the clock
// [R23] Master mode drives the shift clock onto the clock pin
// [R24] Baud generator held in reset while all three enables are clear
// [R25] Single-word enable clears itself after its word arrives
// [R26] Synchronous mode selected by bit 4 of transmit status/control
// [R27] Master receive clocks only while enabled, stopping after a single word
// [R28] Half duplex: receive enable releases the data pin from the transmitter
package usr_pkg;
    localparam logic [7:0] USR_OFS_INTCTL = 8'h0b;
    localparam logic [7:0] USR_OFS_FLAGS = 8'h0c;
    localparam logic [7:0] USR_OFS_RXSC = 8'h18;
    localparam logic [7:0] USR_OFS_TXBUF = 8'h19;
    localparam logic [7:0] USR_OFS_RXHEAD = 8'h1a;
    localparam logic [7:0] USR_OFS_ENAB = 8'h8c;
    localparam logic [7:0] USR_OFS_TXSC = 8'h98;
    localparam logic [7:0] USR_OFS_BAUD = 8'h99;
    localparam logic [7:0] USR_RST_ZERO = 8'h00;
    localparam logic [7:0] USR_RST_TXSC = 8'h02;
    localparam logic [7:0] USR_WM_FLAGS = 8'h4f;
    localparam logic [7:0] USR_WM_RXSC = 8'hf0;
    localparam logic [7:0] USR_WM_TXSC = 8'hf5;
    localparam logic [7:0] USR_WM_ENAB = 8'h7f;
    localparam int USR_B_GIE = 7;
    localparam int USR_B_PERIPHERAL_INTERRUPT_ENABLE = 6;
    localparam int USR_B_RECEIVE_COMPLETE_FLAG = 5;
    localparam int USR_B_TRANSMIT_BUFFER_EMPTY_FLAG = 4;
    localparam int USR_B_SERIAL_PORT_ENABLE = 7;
    localparam int USR_B_RX9 = 6;
    localparam int USR_B_SINGLE_WORD_RECEIVE_ENABLE = 5;
    localparam int USR_B_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int USR_B_CLOCK_SOURCE_MASTER_BIT = 7;
    localparam int USR_B_TX9 = 6;
    localparam int USR_B_TRANSMIT_ENABLE_BIT = 5;
    localparam int USR_B_SYNC = 4;
    localparam int USR_B_TRMT = 1;
    localparam int USR_B_TRANSMIT_NINTH_BIT = 0;
    localparam logic [3:0] USR_BITS_8 = 4'h8;
    localparam logic [3:0] USR_BITS_9 = 4'h9;
    localparam logic [1:0] USR_FIFO_FULL = 2'h2;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } usr_bus_t;
    typedef struct packed {
        logic ck;
        logic dt;
    } usr_pin_in_t;
    typedef struct packed {
        logic ck_o;
        logic ck_oe;
        logic dt_o;
        logic dt_oe;
    } usr_pin_out_t;
    typedef struct packed {
        logic [7:0] intctl;
        logic [7:0] flags_oth;
        logic [7:0] rxsc;
        logic overrun_error_bit;
        logic [7:0] txsc;
        logic [7:0] enab;
        logic [7:0] baud;
        logic [7:0] txbuf;
        logic txbuf_full;
        logic [8:0] transmit_shift_register;
        logic [3:0] tx_cnt;
        logic trmt;
        logic dout;
        logic [7:0] brg_cnt;
        logic sck;
        logic ck_s1;
        logic ck_s2;
        logic ck_s3;
        logic dt_s1;
        logic dt_s2;
        logic [8:0] receive_shift_register;
        logic [3:0] rx_cnt;
        logic [1:0][8:0] fifo;
        logic [1:0] fcnt;
        logic rd_ptr;
        logic [7:0] rdata;
    } usr_st_t;
endpackage : usr_pkg

//--- tb/usr_sync_partner.sv
`timescale 1ns/10ps
module usr_sync_partner (
    input wire logic clk_sys,
    input wire logic restart,
    input wire logic [8:0] base,
    input wire logic [3:0] nbits,
    input wire logic go,
    input wire logic clk_line,
    input wire logic dat_line,
    output logic clk_drv = 1'b0,
    output logic dat_drv = 1'b0,
    output logic [8:0] got = 9'h000,
    output logic busy = 1'b0
);
    logic clk_last = 1'b0;
    logic [3:0] idx = 4'h0;
    logic [8:0] word = 9'h000;
    logic [2:0] half = 3'h0;
    logic [3:0] n = 4'h0;
    always @(posedge clk_sys)
    begin
        clk_last <= clk_line;
        if (restart)
        begin
            idx <= 4'h0;
            word <= base;
        end
        else if (clk_line && !clk_last && !busy)
        begin
            // Change on the rising edge so the bit is settled at the sampling edge
            dat_drv <= word[idx];
            idx <= (idx == nbits - 4'h1) ? 4'h0 : idx + 4'h1;
            if (idx == nbits - 4'h1)
                word <= word + 9'h001;
        end
        if (go && !busy)
        begin
            busy <= 1'b1;
            half <= 3'h0;
            n <= 4'h0;
        end
        else if (busy)
        begin
            half <= half + 3'h1;
            if (half == 3'h7)
            begin
                // Own clock only within a frame, low between frames
                clk_drv <= !clk_drv;
                if (clk_drv)
                begin
                    got[n] <= dat_line;
                    n <= n + 4'h1;
                    busy <= (n != nbits - 4'h1);
                end
            end
        end
    end
endmodule : usr_sync_partner

//--- tb/usart_sync_rx_and_slave_tx_tb_top.sv
`timescale 1ns/10ps
module usart_sync_rx_and_slave_tx_tb_top;
    import usr_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    usr_bus_t bus = '0;
    logic [7:0] rdata;
    logic core_sleep = 1'b0;
    logic wake_request;
    logic irq_request;
    usr_pin_in_t pin_in;
    usr_pin_out_t pin_out;
    logic far_clk;
    logic far_dat;
    logic restart = 1'b0;
    logic go = 1'b0;
    logic busy;
    logic [8:0] base = 9'h000;
    logic [8:0] got;
    logic [3:0] nbits = 4'h8;
    logic [31:0] seed = 32'he3719c18;
    logic [8:0] w;
    logic [8:0] cnt;
    logic [7:0] ofs [8] = '{USR_OFS_INTCTL, USR_OFS_FLAGS, USR_OFS_RXSC, USR_OFS_TXBUF,
        USR_OFS_RXHEAD, USR_OFS_ENAB, USR_OFS_TXSC, USR_OFS_BAUD};
    logic [7:0] rstv [8] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    int errors = 0;
    int comparisons = 0;
    always #2 clk_sys = ~clk_sys;
    assign pin_in.ck = pin_out.ck_oe ? pin_out.ck_o : far_clk;
    assign pin_in.dt = pin_out.dt_oe ? pin_out.dt_o : far_dat;
    usr_top dut (.clk_sys(clk_sys), .resetn(resetn), .bus(bus), .rdata(rdata),
        .core_sleep(core_sleep), .wake_request(wake_request), .irq_request(irq_request),
        .pin_in(pin_in), .pin_out(pin_out));
    usr_sync_partner partner (.clk_sys(clk_sys), .restart(restart), .base(base),
        .nbits(nbits), .go(go), .clk_line(pin_in.ck), .dat_line(pin_in.dt),
        .clk_drv(far_clk), .dat_drv(far_dat), .got(got), .busy(busy));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
        @(posedge clk_sys);
        bus.we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.re <= 1'b1;
        @(posedge clk_sys);
        bus.re <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(what, {1'b0, exp}, {1'b0, v & m});
    endtask : rchk
    task automatic poll(input logic [7:0] a, input logic [7:0] m);
        logic [7:0] v = 8'h00;
        for (int i = 0; i < 300 && (v & m) != m; i++)
            rd(a, v);
        if ((v & m) != m)
            errors++;
    endtask : poll
    task automatic start(input logic [8:0] v, input logic [3:0] nb);
        base <= v;
        nbits <= nb;
        restart <= 1'b1;
        @(posedge clk_sys);
        restart <= 1'b0;
    endtask : start
    task automatic send;
        @(posedge clk_sys);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 400 && busy; i++)
            @(posedge clk_sys);
        if (busy)
            errors++;
        repeat (8) @(posedge clk_sys);
    endtask : send
    initial
    begin
        #80000;
        errors++;
        wrap_up();
    end
    initial
    begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rchk("reset value", ofs[i], 8'hff, rstv[i]);
        rchk("unmapped", 8'h55, 8'hff, 8'h00);
        wr(USR_OFS_FLAGS, 8'hff);
        rchk("flags write", USR_OFS_FLAGS, 8'hff, 8'h5f);
        wr(USR_OFS_FLAGS, 8'h00);
        seed = lfsr(seed);
        // Half period stays well above the two-stage pin synchroniser
        wr(USR_OFS_BAUD, 8'h04 + {5'h00, seed[2:0]});
        wr(USR_OFS_TXSC, 8'h90);
        w = seed[16:8];
        start(w, 4'h8);
        wr(USR_OFS_RXSC, 8'ha0);
        poll(USR_OFS_FLAGS, 8'h20);
        rchk("single status", USR_OFS_RXSC, 8'hff, 8'h80);
        rchk("single word", USR_OFS_RXHEAD, 8'hff, w[7:0]);
        rchk("flag after read", USR_OFS_FLAGS, 8'h20, 8'h00);
        cnt = 9'h000;
        repeat (100)
        begin
            @(posedge clk_sys);
            #1 cnt += {8'h00, pin_out.ck_o};
        end
        chk("clock idle", 9'h000, cnt);
        seed = lfsr(seed);
        w = seed[8:0];
        start(w, 4'h9);
        wr(USR_OFS_RXSC, 8'hf0);
        poll(USR_OFS_RXSC, 8'h02);
        wr(USR_OFS_ENAB, 8'h20);
        wr(USR_OFS_INTCTL, 8'hc0);
        #1 chk("irq on", 9'h001, {8'h00, irq_request});
        wr(USR_OFS_ENAB, 8'h00);
        #1 chk("irq masked", 9'h000, {8'h00, irq_request});
        rchk("flag unmasked", USR_OFS_FLAGS, 8'h20, 8'h20);
        rchk("ninth 0", USR_OFS_RXSC, 8'h03, {6'h00, 1'b1, w[8]});
        rchk("word 0", USR_OFS_RXHEAD, 8'hff, w[7:0]);
        // Let more words finish while overrun stands; none may enter
        repeat (300) @(posedge clk_sys);
        w = w + 9'h001;
        rchk("ninth 1", USR_OFS_RXSC, 8'h03, {6'h00, 1'b1, w[8]});
        rchk("word 1", USR_OFS_RXHEAD, 8'hff, w[7:0]);
        rchk("flag empty", USR_OFS_FLAGS, 8'h20, 8'h00);
        // Second write covers a word finishing in the very clearing cycle
        wr(USR_OFS_RXSC, 8'h80);
        wr(USR_OFS_RXSC, 8'h80);
        rchk("overrun clear", USR_OFS_RXSC, 8'h02, 8'h00);
        seed = lfsr(seed);
        w = seed[8:0];
        // Transmit nine-bit option is off, so the partner clocks eight bits per word
        start(w, 4'h8);
        wr(USR_OFS_TXSC, 8'h30);
        wr(USR_OFS_ENAB, 8'h10);
        core_sleep <= 1'b1;
        wr(USR_OFS_TXBUF, w[7:0]);
        wr(USR_OFS_TXBUF, ~w[7:0]);
        rchk("empty flag held", USR_OFS_FLAGS, 8'h10, 8'h00);
        chk("no wake", 9'h000, {8'h00, wake_request});
        chk("data driven", 9'h001, {8'h00, pin_out.dt_oe});
        send();
        chk("slave word 0", {1'b0, w[7:0]}, {1'b0, got[7:0]});
        rchk("empty flag set", USR_OFS_FLAGS, 8'h10, 8'h10);
        chk("wake", 9'h001, {8'h00, wake_request});
        chk("vector", 9'h001, {8'h00, irq_request});
        send();
        chk("slave word 1", {1'b0, ~w[7:0]}, {1'b0, got[7:0]});
        wr(USR_OFS_RXSC, 8'h90);
        #1 chk("data released", 9'h000, {8'h00, pin_out.dt_oe});
        wrap_up();
    end
endmodule : usart_sync_rx_and_slave_tx_tb_top
